/* port_irq_pkg.sv */
// Package with register map, field positions, reset values and carrier types of the port interrupt control block.
package port_irq_pkg;

  // ==========================================================================
  // Register offsets on the plain register port
  // ==========================================================================
  localparam logic [7:0] PEND_ADDR = 8'h8B;
  localparam logic [7:0] CTRL_ADDR = 8'h8C;
  localparam logic [7:0] STAT_ADDR = 8'h90;
  localparam logic [7:0] MASK_ADDR = 8'h91;

  // ==========================================================================
  // Widths and field positions
  // ==========================================================================
  localparam int P2_PINS = 5;
  localparam int PORT_PINS = 8;
  localparam int EVT_W = 4;
  localparam int SPARE_BIT = 6;
  localparam int P2_ALLOW_BIT = 5;
  localparam int P0_HIGH_BIT = 4;
  localparam int P0_LOW_BIT = 3;
  localparam int P2_EDGE_BIT = 2;
  localparam int P1_EDGE_BIT = 1;
  localparam int P0_EDGE_BIT = 0;
  localparam int EV_P2 = 0;
  localparam int EV_P0_LOW = 1;
  localparam int EV_P0_HIGH = 2;
  localparam int EV_P1 = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [4:0] PEND_RESET = 5'h00;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [3:0] STAT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic [7:0] p0_prev;
    logic [7:0] p1_prev;
    logic [4:0] p2_prev;
    logic [7:0] p0_evt;
    logic [7:0] p1_evt;
    logic [4:0] pend;
    logic [6:0] ctrl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [7:0] rdata;
  } state_type;

endpackage : port_irq_pkg

/* port_pin_interrupt_control.sv */
// Edge-triggered interrupt control for the general-purpose input ports.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
// Behaviour
// - Five pending flags, one per port 2 input, sit in bits 4:0 and are all cleared by reset.
// - Control bit 5 lets or stops interrupt requests from all five port 2 inputs together.
// - Control bit 4 lets or stops interrupt requests from port 0 pins 7 to 4.
// - Control bit 3 lets or stops interrupt requests from port 0 pins 3 to 0.
// - Control bit 2 picks the rising edge (0) or the falling edge (1) for every port 2 input.
// - Control bit 1 picks the rising edge (0) or the falling edge (1) for all port 1 inputs.
// - Control bit 0 picks the rising edge (0) or the falling edge (1) for all port 0 inputs.
module port_pin_interrupt_control
  import port_irq_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire bus_req_type BUS_REQ,
  output logic [7:0] RDATA,
  input wire logic [7:0] PORT0_IN,
  input wire logic [7:0] PORT1_IN,
  input wire logic [4:0] PORT2_IN,
  output logic [7:0] PORT0_EDGE,
  output logic [7:0] PORT1_EDGE,
  output logic PORT0_LOW_ALLOW,
  output logic PORT0_HIGH_ALLOW,
  output logic PORT2_IRQ,
  output logic IRQ
);

  // ==========================================================================
  // State
  // ==========================================================================
  state_type state_q;
  state_type state_d;
  logic [7:0] p0_edge;
  logic [7:0] p1_edge;
  logic [4:0] p2_edge;
  logic [3:0] events;
  logic wr_pend;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    wr_pend = BUS_REQ.wr && (BUS_REQ.addr == PEND_ADDR);
    wr_ctrl = BUS_REQ.wr && (BUS_REQ.addr == CTRL_ADDR);
    wr_mask = BUS_REQ.wr && (BUS_REQ.addr == MASK_ADDR);
    rd_stat = BUS_REQ.rd && (BUS_REQ.addr == STAT_ADDR);
    // Inputs are synchronous, so the previous sample is the only history needed.
    // A pin that is high when reset lifts is seen as a rising edge in the first cycle.
    if (state_q.ctrl[P0_EDGE_BIT]) begin
      p0_edge = state_q.p0_prev & ~PORT0_IN;
    end else begin
      p0_edge = ~state_q.p0_prev & PORT0_IN;
    end
    if (state_q.ctrl[P1_EDGE_BIT]) begin
      p1_edge = state_q.p1_prev & ~PORT1_IN;
    end else begin
      p1_edge = ~state_q.p1_prev & PORT1_IN;
    end
    if (state_q.ctrl[P2_EDGE_BIT]) begin
      p2_edge = state_q.p2_prev & ~PORT2_IN;
    end else begin
      p2_edge = ~state_q.p2_prev & PORT2_IN;
    end
    events = STAT_RESET;
    events[EV_P2] = (|p2_edge) && state_q.ctrl[P2_ALLOW_BIT];
    events[EV_P0_LOW] = (|p0_edge[3:0]) && state_q.ctrl[P0_LOW_BIT];
    events[EV_P0_HIGH] = (|p0_edge[7:4]) && state_q.ctrl[P0_HIGH_BIT];
    events[EV_P1] = |p1_edge;
    state_d.p0_prev = PORT0_IN;
    state_d.p1_prev = PORT1_IN;
    state_d.p2_prev = PORT2_IN;
    state_d.p0_evt = p0_edge;
    state_d.p1_evt = p1_edge;
    // A new edge wins over a clearing write in the same cycle.
    if (wr_pend) begin
      state_d.pend = state_q.pend & BUS_REQ.wdata[4:0];
    end
    state_d.pend = state_d.pend | p2_edge;
    if (wr_ctrl) begin
      state_d.ctrl = BUS_REQ.wdata[6:0];
    end
    if (wr_mask) begin
      state_d.mask = BUS_REQ.wdata[3:0];
    end
    if (rd_stat) begin
      state_d.status = STAT_RESET;
    end
    state_d.status = state_d.status | events;
    state_d.rdata = RDATA_RESET;
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        PEND_ADDR: state_d.rdata = {3'h0, state_q.pend};
        CTRL_ADDR: state_d.rdata = {1'h0, state_q.ctrl};
        STAT_ADDR: state_d.rdata = {4'h0, state_q.status};
        MASK_ADDR: state_d.rdata = {4'h0, state_q.mask};
        default: state_d.rdata = RDATA_RESET;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q.p0_prev <= PORT_RESET;
      state_q.p1_prev <= PORT_RESET;
      state_q.p2_prev <= PEND_RESET;
      state_q.p0_evt <= PORT_RESET;
      state_q.p1_evt <= PORT_RESET;
      state_q.pend <= PEND_RESET;
      state_q.ctrl <= CTRL_RESET;
      state_q.status <= STAT_RESET;
      state_q.mask <= MASK_RESET;
      state_q.rdata <= RDATA_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Port 0 and port 1 flags live in a neighbouring block, so their edges leave as pulses.
  assign RDATA = state_q.rdata;
  assign PORT0_EDGE = state_q.p0_evt;
  assign PORT1_EDGE = state_q.p1_evt;
  assign PORT0_LOW_ALLOW = state_q.ctrl[P0_LOW_BIT];
  assign PORT0_HIGH_ALLOW = state_q.ctrl[P0_HIGH_BIT];
  assign PORT2_IRQ = state_q.ctrl[P2_ALLOW_BIT] && (|state_q.pend);
  assign IRQ = |(state_q.status & state_q.mask);

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_write_pend;
    BUS_REQ.wr && (BUS_REQ.addr == PEND_ADDR);
  endsequence

  sequence s_read_pend;
    BUS_REQ.rd && (BUS_REQ.addr == PEND_ADDR);
  endsequence

  sequence s_read_ctrl;
    BUS_REQ.rd && (BUS_REQ.addr == CTRL_ADDR);
  endsequence

  sequence s_p2_rise0;
    !state_q.ctrl[P2_EDGE_BIT] && $rose(PORT2_IN[0]);
  endsequence

  sequence s_p2_fall0;
    state_q.ctrl[P2_EDGE_BIT] && $fell(PORT2_IN[0]);
  endsequence

  property p_pend_clear_on_reset;
    @(posedge CORE_CLK) $rose(RESETN) |-> (state_q.pend == PEND_RESET);
  endproperty
  a_pend_clear_on_reset: assert property (p_pend_clear_on_reset)
    else $error("Pending flags not clear after reset.");

  property p_pend_readback;
    s_read_pend |=> (RDATA == {3'h0, $past(state_q.pend)});
  endproperty
  a_pend_readback: assert property (p_pend_readback)
    else $error("Pending flag read returned wrong value.");

  property p_p2_irq_gate;
    (state_q.pend != PEND_RESET) |-> (PORT2_IRQ == state_q.ctrl[P2_ALLOW_BIT]);
  endproperty
  a_p2_irq_gate: assert property (p_p2_irq_gate)
    else $error("Port 2 request does not follow its allow bit.");

  property p_p2_blocked_no_status;
    (!state_q.ctrl[P2_ALLOW_BIT] && !rd_stat && !state_q.status[EV_P2]) ##1
      (!BUS_REQ.rd || BUS_REQ.addr != STAT_ADDR) |-> !state_q.status[EV_P2] || $past(|p2_edge) == 1'b0;
  endproperty
  a_p2_blocked_no_status: assert property (p_p2_blocked_no_status)
    else $error("Blocked port 2 edge raised status.");

  property p_p0_high_event;
    (|p0_edge[7:4]) && state_q.ctrl[P0_HIGH_BIT] |=> state_q.status[EV_P0_HIGH];
  endproperty
  a_p0_high_event: assert property (p_p0_high_event)
    else $error("Allowed upper port 0 edge lost.");

  property p_p0_high_blocked;
    !state_q.ctrl[P0_HIGH_BIT] && !state_q.status[EV_P0_HIGH] |=> !state_q.status[EV_P0_HIGH];
  endproperty
  a_p0_high_blocked: assert property (p_p0_high_blocked)
    else $error("Blocked upper port 0 edge raised status.");

  property p_p0_low_event;
    (|p0_edge[3:0]) && state_q.ctrl[P0_LOW_BIT] |=> state_q.status[EV_P0_LOW];
  endproperty
  a_p0_low_event: assert property (p_p0_low_event)
    else $error("Allowed lower port 0 edge lost.");

  property p_p0_low_blocked;
    !state_q.ctrl[P0_LOW_BIT] && !state_q.status[EV_P0_LOW] |=> !state_q.status[EV_P0_LOW];
  endproperty
  a_p0_low_blocked: assert property (p_p0_low_blocked)
    else $error("Blocked lower port 0 edge raised status.");

  property p_p2_rise_sets;
    s_p2_rise0 |=> state_q.pend[0] ##1 state_q.pend[0] || $past(BUS_REQ.wr);
  endproperty
  a_p2_rise_sets: assert property (p_p2_rise_sets)
    else $error("Rising edge on port 2 pin 0 did not set its flag.");

  property p_p2_fall_sets;
    s_p2_fall0 |=> state_q.pend[0];
  endproperty
  a_p2_fall_sets: assert property (p_p2_fall_sets)
    else $error("Falling edge on port 2 pin 0 did not set its flag.");

  property p_p2_wrong_edge;
    state_q.ctrl[P2_EDGE_BIT] && $rose(PORT2_IN[0]) && !state_q.pend[0] |=> !state_q.pend[0];
  endproperty
  a_p2_wrong_edge: assert property (p_p2_wrong_edge)
    else $error("Rising edge set a flag in falling mode.");

  property p_p1_edge;
    $fell(PORT1_IN[3]) && state_q.ctrl[P1_EDGE_BIT] |=> PORT1_EDGE[3] ##1
      (!PORT1_EDGE[3] || ($past(state_q.ctrl[P1_EDGE_BIT], 2) != $past(state_q.ctrl[P1_EDGE_BIT])));
  endproperty
  a_p1_edge: assert property (p_p1_edge)
    else $error("Port 1 falling edge pulse missing.");

  property p_p1_rise_edge;
    $rose(PORT1_IN[3]) && !state_q.ctrl[P1_EDGE_BIT] |=> PORT1_EDGE[3];
  endproperty
  a_p1_rise_edge: assert property (p_p1_rise_edge)
    else $error("Port 1 rising edge pulse missing.");

  property p_p0_edge;
    $rose(PORT0_IN[7]) && !state_q.ctrl[P0_EDGE_BIT] |=> PORT0_EDGE[7];
  endproperty
  a_p0_edge: assert property (p_p0_edge)
    else $error("Port 0 rising edge pulse missing.");

  property p_p0_no_edge;
    $fell(PORT0_IN[7]) && !state_q.ctrl[P0_EDGE_BIT] |=> !PORT0_EDGE[7];
  endproperty
  a_p0_no_edge: assert property (p_p0_no_edge)
    else $error("Port 0 falling edge pulsed in rising mode.");

  property p_write_zero_clears;
    s_write_pend ##0 !BUS_REQ.wdata[1] ##0 !p2_edge[1] |=> !state_q.pend[1];
  endproperty
  a_write_zero_clears: assert property (p_write_zero_clears)
    else $error("Writing 0 did not clear the pending flag.");

  property p_write_one_keeps;
    s_write_pend ##0 BUS_REQ.wdata[1] ##0 state_q.pend[1] |=> state_q.pend[1];
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps)
    else $error("Writing 1 changed the pending flag.");

  property p_set_wins;
    s_write_pend ##0 p2_edge[2] |=> state_q.pend[2];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Edge lost against a clearing write.");

  property p_flag_holds;
    state_q.pend[3] && !BUS_REQ.wr |=> state_q.pend[3] [*1];
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("Pending flag dropped without a write.");

  property p_ctrl_readback;
    s_read_ctrl |=> (RDATA[7] == 1'b0) && (RDATA[6:0] == $past(state_q.ctrl));
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("Control read returned wrong value.");

  property p_spare_stores;
    BUS_REQ.wr && (BUS_REQ.addr == CTRL_ADDR) |=> state_q.ctrl[SPARE_BIT] == $past(BUS_REQ.wdata[SPARE_BIT]);
  endproperty
  a_spare_stores: assert property (p_spare_stores)
    else $error("Spare control bit did not store.");

  property p_pend_high_zero;
    s_read_pend |=> RDATA[7:5] == 3'h0;
  endproperty
  a_pend_high_zero: assert property (p_pend_high_zero)
    else $error("Unused pending bits read nonzero.");

  property p_rdata_one_cycle;
    !BUS_REQ.rd |=> RDATA == RDATA_RESET;
  endproperty
  a_rdata_one_cycle: assert property (p_rdata_one_cycle)
    else $error("Read data stood outside the answer cycle.");

  property p_irq_level;
    IRQ == |(state_q.status & state_q.mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt output disagrees with status and mask.");

  sequence s_read_stat;
    BUS_REQ.rd && (BUS_REQ.addr == STAT_ADDR);
  endsequence

  // Reading status hands back the old value, so an event in the read cycle must outlive the clear.
  property p_stat_readback;
    s_read_stat |=> (RDATA == {4'h0, $past(state_q.status)});
  endproperty
  a_stat_readback: assert property (p_stat_readback)
    else $error("Status read returned wrong value.");

  property p_stat_read_clears;
    s_read_stat ##0 (events == STAT_RESET) |=> (state_q.status == STAT_RESET);
  endproperty
  a_stat_read_clears: assert property (p_stat_read_clears)
    else $error("Status read did not clear the status bits.");

  property p_stat_set_wins;
    s_read_stat ##0 events[EV_P2] |=> state_q.status[EV_P2];
  endproperty
  a_stat_set_wins: assert property (p_stat_set_wins)
    else $error("Port 2 event lost against a status read.");

  property p_p2_allowed_status;
    (|p2_edge) && state_q.ctrl[P2_ALLOW_BIT] |=> state_q.status[EV_P2];
  endproperty
  a_p2_allowed_status: assert property (p_p2_allowed_status)
    else $error("Allowed port 2 edge did not raise status.");

  property p_p1_status;
    (|p1_edge) |=> state_q.status[EV_P1];
  endproperty
  a_p1_status: assert property (p_p1_status)
    else $error("Port 1 edge did not raise status.");

  property p_mask_readback;
    BUS_REQ.rd && (BUS_REQ.addr == MASK_ADDR) |=> (RDATA == {4'h0, $past(state_q.mask)});
  endproperty
  a_mask_readback: assert property (p_mask_readback)
    else $error("Mask read returned wrong value.");

endmodule : port_pin_interrupt_control

/* pin_bank.sv */
// Pad model that presents the bench's requested pin levels to the port inputs.
`timescale 1ns/100ps
module pin_bank
  import port_irq_pkg::*;
(
  input wire logic [7:0] lvl0,
  input wire logic [7:0] lvl1,
  input wire logic [4:0] lvl2,
  output logic [7:0] pin0,
  output logic [7:0] pin1,
  output logic [4:0] pin2
);
  // ==========================================================================
  // Pads
  // ==========================================================================
  // The inputs are always driven, so no released or floating state can occur.
  assign pin0 = lvl0;
  assign pin1 = lvl1;
  assign pin2 = lvl2;
endmodule : pin_bank

/* tb.sv */
// Self-checking bench for the port interrupt control block.
`timescale 1ns/100ps
module tb
  import port_irq_pkg::*;
;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic clk;
  logic rst_n;
  bus_req_type req;
  logic [7:0] rdata, edge0, edge1, lvl0, lvl1, pin0, pin1, a0, a1, s0, s1, ctrl_m, wd;
  logic [4:0] lvl2, pin2, a2, s2, pend_m;
  logic [3:0] stat_m, mask_m;
  logic low_allow, high_allow, p2_irq, irq;
  logic [31:0] seed;
  int err_total;
  int check_count;

  port_pin_interrupt_control dut (.CORE_CLK(clk), .RESETN(rst_n), .BUS_REQ(req), .RDATA(rdata),
    .PORT0_IN(pin0), .PORT1_IN(pin1), .PORT2_IN(pin2), .PORT0_EDGE(edge0), .PORT1_EDGE(edge1),
    .PORT0_LOW_ALLOW(low_allow), .PORT0_HIGH_ALLOW(high_allow), .PORT2_IRQ(p2_irq), .IRQ(irq));
  pin_bank pads (.lvl0(lvl0), .lvl1(lvl1), .lvl2(lvl2), .pin0(pin0), .pin1(pin1), .pin2(pin2));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  function automatic logic [7:0] edg(input logic [7:0] o, input logic [7:0] n, input logic fall);
    return fall ? (o & ~n) : (~o & n);
  endfunction : edg

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1;
    chk(e, rdata);
  endtask : rd_chk

  // Random pin traffic; the last three cycles hold the pins so later reads see a quiet port.
  task automatic run(input int n);
    logic [7:0] e0, e1, e2;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      e0 = edg(s0, a0, ctrl_m[P0_EDGE_BIT]);
      e1 = edg(s1, a1, ctrl_m[P1_EDGE_BIT]);
      e2 = edg({3'h0, s2}, {3'h0, a2}, ctrl_m[P2_EDGE_BIT]);
      s0 = a0;
      s1 = a1;
      s2 = a2;
      pend_m |= e2[4:0];
      stat_m |= {|e1, ctrl_m[P0_HIGH_BIT] & |e0[7:4], ctrl_m[P0_LOW_BIT] & |e0[3:0], ctrl_m[P2_ALLOW_BIT] & |e2};
      if (i < n - 3) begin
        seed = xs(seed);
        a0 = seed[7:0];
        a1 = seed[15:8];
        a2 = seed[20:16];
        lvl0 <= a0;
        lvl1 <= a1;
        lvl2 <= a2;
      end
      #1;
      chk(e0, edge0);
      chk(e1, edge1);
      chk({7'h00, ctrl_m[P2_ALLOW_BIT] & |pend_m}, {7'h00, p2_irq});
      chk({7'h00, |(stat_m & mask_m)}, {7'h00, irq});
    end
  endtask : run

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 32'h00001B55;
    req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    rst_n = 1'b0;
    {lvl0, lvl1, lvl2, a0, a1, a2, s0, s1, s2} = '0;
    {ctrl_m, pend_m, stat_m, mask_m} = '0;
    err_total = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(PEND_ADDR, 8'h00);
    rd_chk(CTRL_ADDR, 8'h00);
    rd_chk(STAT_ADDR, 8'h00);
    rd_chk(MASK_ADDR, 8'h00);
    @(posedge clk);
    #1;
    chk(8'h00, rdata);
    bus_wr(8'h55, 8'hFF);
    rd_chk(8'h55, 8'h00);
    // USB is not in use here, so the port 0 falling edge may be selected.
    for (int r = 0; r < 10; r++) begin
      seed = xs(seed);
      wd = (r == 0) ? 8'h80 : (r == 1) ? 8'hFF : seed[7:0];
      bus_wr(CTRL_ADDR, wd);
      ctrl_m = wd & 8'h7F;
      rd_chk(CTRL_ADDR, ctrl_m);
      chk({6'h00, ctrl_m[P0_HIGH_BIT], ctrl_m[P0_LOW_BIT]}, {6'h00, high_allow, low_allow});
      mask_m = seed[11:8];
      bus_wr(MASK_ADDR, {4'h0, mask_m});
      rd_chk(MASK_ADDR, {4'h0, mask_m});
      run(24);
      rd_chk(PEND_ADDR, {3'h0, pend_m});
      bus_wr(PEND_ADDR, seed[23:16]);
      pend_m &= seed[20:16];
      rd_chk(PEND_ADDR, {3'h0, pend_m});
      rd_chk(STAT_ADDR, {4'h0, stat_m});
      stat_m = 4'h0;
      rd_chk(STAT_ADDR, 8'h00);
      chk(8'h00, {7'h00, irq});
    end
    // Corner: a clearing write and then a status read each meet a fresh port 2 rise; the rise wins both times.
    bus_wr(CTRL_ADDR, 8'h20);
    ctrl_m = 8'h20;
    lvl2 <= 5'h00;
    @(posedge clk);
    lvl2 <= 5'h1F;
    req <= '{addr: PEND_ADDR, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    lvl2 <= 5'h00;
    req <= '{addr: PEND_ADDR, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    rd_chk(PEND_ADDR, 8'h1F);
    @(posedge clk);
    lvl2 <= 5'h1F;
    req <= '{addr: STAT_ADDR, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '{addr: STAT_ADDR, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1;
    chk(8'h01, rdata);
    rd_chk(STAT_ADDR, 8'h01);
    s2 = 5'h1F;
    a2 = 5'h1F;
    pend_m = 5'h1F;
    stat_m = 4'h0;
    chk(8'h00, {7'h00, irq});
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule : tb
